// [core/plab_bank.sv]
`timescale 1ns/1ps
// Behaviour
// - attribute count reads 13, read only
// - format accepts INT or REAL, default INT
// - format and units locked while executing
// - format locked during active I/O use
// - instance 7 consume activation forces INT
// - 16-bit units, pressure codes, default counts
// - control mode volatile, zero after reset
// - modes 0 normal, 1 closed, 2 open
// - mode 3 holds last analog output
// - mode 4 follows actuator safe state
// - signed counts, 24576 full, 27033 max
// - negative setpoint clamps to zero
// - setpoint above 27033 clamps to 110 percent
// - measured value mirrors linked sensor
// - read only status byte with flags
// - alarm flag only when alarm enabled
// - warning flag only when warning enabled
// - 16-bit alarm and warning settling times
// - alarm when deviation exceeds alarm band
// - warning when deviation exceeds warning band
// - 32-bit ramp time, zero disables ramp
// - alarm bit 0, warning bit 1, rest zero
// - settling timer masks flags after setpoint
`include "plab_consts.svh"
module plab_bank
  import plab_pkg::*;
#(
  parameter int CYC_PER_MS = `PLAB_MS_NS / `PLAB_CLK_NS
) (
  input wire logic I_CLOCK,
  input wire logic I_RESET_N,
  input plab_req_s I_REQ, // attribute access
  input wire logic I_EXECUTING, // device in executing state
  input wire logic I_IO_ACTIVE, // typed attribute used by an active connection
  input wire logic I_ASM7_CONSUME, // instance 7 on consume path, connection active
  input wire logic [15:0] I_SENSOR, // linked sensor value
  input wire logic [15:0] I_LOOP_OUT, // controller output in normal mode
  input wire logic [15:0] I_AO_VALUE, // last updated analog output
  input wire logic [1:0] I_SAFE_STATE, // actuator safe state selection
  input wire logic [15:0] I_SAFE_VALUE, // actuator safe value
  output plab_rsp_s O_RSP,
  output logic [15:0] O_EFF_SETPOINT,
  output logic [15:0] O_ACTUATOR,
  output logic [7:0] O_FLAGS,
  output logic O_RAMPING
);
  // -----------------------------------------------------------------
  // elaboration check
  // -----------------------------------------------------------------
  if (CYC_PER_MS < 2) begin : g_bad_div
    $error("divider needs at least two cycles per tick");
  end

  // last divider count; the tick is one cycle wide so timers step once
  localparam logic [31:0] DIV_LAST = 32'(CYC_PER_MS - 1);

  plab_state_s st_ff; // registered state
  plab_state_s nxt_st; // next state
  logic alm_settled; // alarm mask expired
  logic wrn_settled; // warning mask expired
  logic wr; // accepted write strobe
  logic rd; // read strobe
  logic [15:0] wd16; // low half of write data
  logic signed [16:0] dev; // measured minus effective
  logic [16:0] dev_abs; // magnitude of deviation
  logic signed [16:0] delta; // ramp span
  logic [31:0] el1; // elapsed after this tick
  logic signed [49:0] prod; // span times elapsed
  logic signed [49:0] quo; // scaled ramp step
  logic [16:0] ramp_sum; // start plus step
  logic [15:0] clamped; // clamped write value
  logic unit_ok; // units code acceptable

  // -----------------------------------------------------------------
  // settling timers
  // -----------------------------------------------------------------
  plab_settle_timer #(.W(16)) u_alm_timer (
    .i_clock(I_CLOCK),
    .i_reset_n(I_RESET_N),
    .i_start(st_ff.settle_go),
    .i_tick(st_ff.tick),
    .i_len(st_ff.alm_settle),
    .o_settled(alm_settled)
  );

  plab_settle_timer #(.W(16)) u_wrn_timer (
    .i_clock(I_CLOCK),
    .i_reset_n(I_RESET_N),
    .i_start(st_ff.settle_go),
    .i_tick(st_ff.tick),
    .i_len(st_ff.wrn_settle),
    .o_settled(wrn_settled)
  );

  // -----------------------------------------------------------------
  // decode helpers
  // -----------------------------------------------------------------
  // strobes, clamp, deviation and ramp step, all settled before the edge
  // so that a write lands at the very next edge
  always_comb begin
    wr = I_REQ.req && I_REQ.write;
    rd = I_REQ.req && !I_REQ.write;
    wd16 = I_REQ.wdata[15:0];
    // negative counts are invalid and clamp to zero
    if ($signed(wd16) < 0) begin
      clamped = 16'h0000;
    end else if (wd16 > `PLAB_CNT_MAX) begin
      clamped = `PLAB_CNT_MAX;
    end else begin
      clamped = wd16;
    end
    unit_ok = (wd16 == `PLAB_UNIT_COUNTS) || (wd16 >= `PLAB_UNIT_P_LO && wd16 <= `PLAB_UNIT_P_HI);
    dev = $signed({1'b0, I_SENSOR}) - $signed({1'b0, st_ff.eff});
    dev_abs = dev[16] ? 17'(-dev) : 17'(dev);
    // ramp interpolation; a divider is traded for exact linear placement
    delta = $signed({1'b0, st_ff.target}) - $signed({1'b0, st_ff.start});
    el1 = st_ff.elapsed + 32'h0000_0001;
    prod = $signed({{33{delta[16]}}, delta}) * $signed({18'h0, el1});
    quo = (st_ff.ramp_ms == 32'h0) ? 50'sh0 : prod / $signed({18'h0, st_ff.ramp_ms});
    ramp_sum = 17'({1'b0, st_ff.start} + quo[16:0]);
  end

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.settle_go = 1'b0;
    nxt_st.rsp = '{ack: 1'b0, err: 1'b0, rdata: 32'h0};

    // millisecond tick divider
    if (st_ff.div == DIV_LAST) begin
      nxt_st.div = 32'h0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.div = st_ff.div + 32'h1;
      nxt_st.tick = 1'b0;
    end

    // ramp advance on each tick
    // truncation toward zero keeps every step short of the target
    if (st_ff.ramping && st_ff.tick) begin
      nxt_st.elapsed = el1;
      if (el1 >= st_ff.ramp_ms) begin
        nxt_st.eff = st_ff.target;
        nxt_st.ramping = 1'b0;
      end else begin
        nxt_st.eff = ramp_sum[15:0];
      end
    end

    // attribute access
    if (I_REQ.req) begin
      nxt_st.rsp.ack = 1'b1;
    end
    if (rd) begin
      unique case (I_REQ.attr)
        `PLAB_ID_NUM_ATTR: nxt_st.rsp.rdata = {24'h0, `PLAB_NUM_ATTR};
        `PLAB_ID_ATTR_LIST: nxt_st.rsp.rdata = {24'h0, `PLAB_NUM_ATTR};
        `PLAB_ID_FORMAT: nxt_st.rsp.rdata = {24'h0, st_ff.fmt};
        `PLAB_ID_UNITS: nxt_st.rsp.rdata = {16'h0, st_ff.units};
        `PLAB_ID_MODE: nxt_st.rsp.rdata = {29'h0, st_ff.mode};
        `PLAB_ID_TARGET: nxt_st.rsp.rdata = {16'h0, st_ff.target};
        `PLAB_ID_MEASURED: nxt_st.rsp.rdata = {16'h0, I_SENSOR};
        `PLAB_ID_FLAGS: nxt_st.rsp.rdata = {24'h0, st_ff.flags};
        `PLAB_ID_ALM_EN: nxt_st.rsp.rdata = {31'h0, st_ff.alm_en};
        `PLAB_ID_WRN_EN: nxt_st.rsp.rdata = {31'h0, st_ff.wrn_en};
        `PLAB_ID_ALM_SETTLE: nxt_st.rsp.rdata = {16'h0, st_ff.alm_settle};
        `PLAB_ID_ALM_BAND: nxt_st.rsp.rdata = {16'h0, st_ff.alm_band};
        `PLAB_ID_WRN_SETTLE: nxt_st.rsp.rdata = {16'h0, st_ff.wrn_settle};
        `PLAB_ID_WRN_BAND: nxt_st.rsp.rdata = {16'h0, st_ff.wrn_band};
        `PLAB_ID_RAMP: nxt_st.rsp.rdata = st_ff.ramp_ms;
        default: nxt_st.rsp.err = 1'b1; // unknown attribute
      endcase
    end
    if (wr) begin
      unique case (I_REQ.attr)
        `PLAB_ID_FORMAT: begin
          // locked while executing or while a connection uses typed values
          if (I_EXECUTING || I_IO_ACTIVE) begin
            nxt_st.rsp.err = 1'b1;
          end else if (I_REQ.wdata[7:0] == `PLAB_FMT_INT || I_REQ.wdata[7:0] == `PLAB_FMT_REAL) begin
            nxt_st.fmt = I_REQ.wdata[7:0];
          end else begin
            nxt_st.rsp.err = 1'b1;
          end
        end
        `PLAB_ID_UNITS: begin
          if (I_EXECUTING || !unit_ok) begin
            nxt_st.rsp.err = 1'b1;
          end else begin
            nxt_st.units = wd16;
          end
        end
        `PLAB_ID_MODE: begin
          if (I_REQ.wdata[7:0] > 8'h04) begin
            nxt_st.rsp.err = 1'b1; // unknown mode
          end else begin
            nxt_st.mode = plab_mode_e'(I_REQ.wdata[2:0]);
            // capture the output only on entry so repeated writes keep the old hold;
            // safe state entry captures too, its hold option wants the value from just before
            if (I_REQ.wdata[2:0] == 3'(MODE_HOLD) && st_ff.mode != MODE_HOLD) begin
              nxt_st.hold_val = I_AO_VALUE;
            end else if (I_REQ.wdata[2:0] == 3'(MODE_SAFE) && st_ff.mode != MODE_SAFE) begin
              nxt_st.hold_val = I_AO_VALUE;
            end
          end
        end
        `PLAB_ID_TARGET: begin
          nxt_st.target = clamped;
          nxt_st.settle_go = 1'b1;
          if (st_ff.ramp_ms == 32'h0) begin
            nxt_st.eff = clamped;
            nxt_st.ramping = 1'b0;
          end else begin
            nxt_st.start = st_ff.eff;
            nxt_st.elapsed = 32'h0;
            nxt_st.ramping = 1'b1;
          end
        end
        `PLAB_ID_ALM_EN: begin
          if (I_REQ.wdata[7:0] > 8'h01) begin
            nxt_st.rsp.err = 1'b1; // boolean only
          end else begin
            nxt_st.alm_en = I_REQ.wdata[0];
          end
        end
        `PLAB_ID_WRN_EN: begin
          if (I_REQ.wdata[7:0] > 8'h01) begin
            nxt_st.rsp.err = 1'b1; // boolean only
          end else begin
            nxt_st.wrn_en = I_REQ.wdata[0];
          end
        end
        `PLAB_ID_ALM_SETTLE: nxt_st.alm_settle = wd16;
        `PLAB_ID_ALM_BAND: nxt_st.alm_band = wd16;
        `PLAB_ID_WRN_SETTLE: nxt_st.wrn_settle = wd16;
        `PLAB_ID_WRN_BAND: nxt_st.wrn_band = wd16;
        `PLAB_ID_RAMP: nxt_st.ramp_ms = I_REQ.wdata;
        default: nxt_st.rsp.err = 1'b1; // read only or unknown
      endcase
    end

    // connection activation overrides any format, and INT then stays
    // only the rising edge forces, so a level held high forces once
    nxt_st.asm7_q = I_ASM7_CONSUME;
    if (I_ASM7_CONSUME && !st_ff.asm7_q) begin
      nxt_st.fmt = `PLAB_FMT_INT;
    end

    // loop flags, masked until the settling timers expire
    // live levels, not latched: a bit drops once the deviation is back
    nxt_st.flags = 8'h00;
    nxt_st.flags[`PLAB_BIT_ALARM] = st_ff.alm_en && alm_settled && (dev_abs > {1'b0, st_ff.alm_band});
    nxt_st.flags[`PLAB_BIT_WARN] = st_ff.wrn_en && wrn_settled && (dev_abs > {1'b0, st_ff.wrn_band});

    // actuator drive by override mode
    // hold and safe-state hold share one captured value
    unique case (st_ff.mode)
      MODE_NORMAL: nxt_st.act = I_LOOP_OUT;
      MODE_CLOSED: nxt_st.act = 16'h0000;
      MODE_OPEN: nxt_st.act = `PLAB_CNT_FULL;
      MODE_HOLD: nxt_st.act = st_ff.hold_val;
      MODE_SAFE: begin
        unique case (I_SAFE_STATE)
          2'h0: nxt_st.act = 16'h0000;
          2'h1: nxt_st.act = `PLAB_CNT_FULL;
          2'h2: nxt_st.act = st_ff.hold_val;
          2'h3: nxt_st.act = I_SAFE_VALUE;
        endcase
      end
      default: nxt_st.act = 16'h0000; // illegal code drives closed
    endcase
  end

  // -----------------------------------------------------------------
  // state register
  // -----------------------------------------------------------------
  // constants only under reset; the volatile mode comes back normal
  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      st_ff <= '0;
      st_ff.fmt <= `PLAB_FMT_INT;
      st_ff.units <= `PLAB_UNIT_COUNTS;
      st_ff.mode <= MODE_NORMAL;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // -----------------------------------------------------------------
  // outputs, all from the state register
  // -----------------------------------------------------------------
  // no logic between flop and port, so the bus sees clean levels
  assign O_RSP = st_ff.rsp;
  assign O_EFF_SETPOINT = st_ff.eff;
  assign O_ACTUATOR = st_ff.act;
  assign O_FLAGS = st_ff.flags;
  assign O_RAMPING = st_ff.ramping;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  // single clock domain, all checks silent under reset
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (!I_RESET_N);

  chk_count_read: assert property (rd && I_REQ.attr == `PLAB_ID_NUM_ATTR |=> O_RSP.ack && O_RSP.rdata == 32'hD)
    else $error("attribute count read wrong");
  chk_format_legal: assert property (st_ff.fmt == `PLAB_FMT_INT || st_ff.fmt == `PLAB_FMT_REAL)
    else $error("format holds illegal code");
  chk_exec_lock: assert property (wr && I_EXECUTING && I_REQ.attr inside {`PLAB_ID_FORMAT, `PLAB_ID_UNITS}
    |=> O_RSP.err && $stable(st_ff.units))
    else $error("locked attribute accepted while executing");
  chk_io_lock: assert property (wr && I_IO_ACTIVE && !I_ASM7_CONSUME && I_REQ.attr == `PLAB_ID_FORMAT
    |=> $stable(st_ff.fmt))
    else $error("format changed during connection use");
  chk_asm7_int: assert property ($rose(I_ASM7_CONSUME) |=> ##1 st_ff.fmt == `PLAB_FMT_INT)
    else $error("format not forced to INT");
  chk_mode_drive: assert property (st_ff.mode == MODE_OPEN && $stable(st_ff.mode) |=> O_ACTUATOR == 16'h6000)
    else $error("open mode not fully open");
  chk_target_clamp: assert property (st_ff.target <= 16'h6999)
    else $error("target beyond clamp range");
  chk_flag_gate: assert property (!st_ff.alm_en && !st_ff.wrn_en |=> O_FLAGS == 8'h00)
    else $error("flag raised while disabled");
  chk_ramp_off: assert property (wr && I_REQ.attr == `PLAB_ID_TARGET && st_ff.ramp_ms == 32'h0
    |=> O_EFF_SETPOINT == $past(clamped) && !O_RAMPING)
    else $error("setpoint not applied directly");
  chk_ramp_end: assert property (O_RAMPING && st_ff.tick && !wr && el1 >= st_ff.ramp_ms
    |=> O_EFF_SETPOINT == st_ff.target)
    else $error("ramp did not land on target");
  chk_hold_drive: assert property (st_ff.mode == MODE_HOLD |=> O_ACTUATOR == $past(st_ff.hold_val))
    else $error("hold mode not driving captured value");
  chk_closed_drive: assert property (st_ff.mode == MODE_CLOSED |=> O_ACTUATOR == 16'h0000)
    else $error("closed mode not fully closed");
  chk_alarm_mask: assert property (!alm_settled |=> !O_FLAGS[`PLAB_BIT_ALARM])
    else $error("alarm reported before settling");
  chk_tick_single: assert property (st_ff.tick |=> !st_ff.tick)
    else $error("millisecond tick wider than one cycle");
endmodule

// [core/plab_consts.svh]
`ifndef PLAB_CONSTS_SVH
`define PLAB_CONSTS_SVH
// -----------------------------------------------------------------
// attribute identifiers
// -----------------------------------------------------------------
`define PLAB_ID_NUM_ATTR 8'h01
`define PLAB_ID_ATTR_LIST 8'h02
`define PLAB_ID_FORMAT 8'h03
`define PLAB_ID_UNITS 8'h04
`define PLAB_ID_MODE 8'h05
`define PLAB_ID_TARGET 8'h06
`define PLAB_ID_MEASURED 8'h07
`define PLAB_ID_FLAGS 8'h0A
`define PLAB_ID_ALM_EN 8'h0B
`define PLAB_ID_WRN_EN 8'h0C
`define PLAB_ID_ALM_SETTLE 8'h0D
`define PLAB_ID_ALM_BAND 8'h0E
`define PLAB_ID_WRN_SETTLE 8'h0F
`define PLAB_ID_WRN_BAND 8'h10
`define PLAB_ID_RAMP 8'h13
// -----------------------------------------------------------------
// reset values and codes
// -----------------------------------------------------------------
`define PLAB_NUM_ATTR 8'h0D
`define PLAB_FMT_INT 8'hC3
`define PLAB_FMT_REAL 8'hCA
`define PLAB_UNIT_COUNTS 16'h1001
`define PLAB_UNIT_P_LO 16'h1300
`define PLAB_UNIT_P_HI 16'h13FF
// -----------------------------------------------------------------
// setpoint range in counts and status bits
// -----------------------------------------------------------------
`define PLAB_CNT_FULL 16'h6000
`define PLAB_CNT_MAX 16'h6999
`define PLAB_BIT_ALARM 0
`define PLAB_BIT_WARN 1
// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define PLAB_CLK_NS 4
`define PLAB_MS_NS 1000000
`endif

// [core/plab_pkg.sv]
package plab_pkg;
  // override modes, encoded 0..4 in declaration order
  typedef enum logic [2:0] {MODE_NORMAL, MODE_CLOSED, MODE_OPEN, MODE_HOLD, MODE_SAFE} plab_mode_e;
  // one attribute access from the fieldbus side
  typedef struct packed {
    logic req;
    logic write;
    logic [7:0] attr;
    logic [31:0] wdata;
  } plab_req_s;
  // answer to an access, one cycle later
  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] rdata;
  } plab_rsp_s;
  // settling timer state
  typedef struct packed {
    logic [15:0] cnt;
    logic settled;
  } plab_tmr_s;
  // whole attribute bank state
  typedef struct packed {
    logic [31:0] div;
    logic tick;
    logic [7:0] fmt;
    logic [15:0] units;
    plab_mode_e mode;
    logic [15:0] target;
    logic [15:0] eff;
    logic [15:0] start;
    logic [31:0] elapsed;
    logic ramping;
    logic alm_en;
    logic wrn_en;
    logic [15:0] alm_settle;
    logic [15:0] alm_band;
    logic [15:0] wrn_settle;
    logic [15:0] wrn_band;
    logic [31:0] ramp_ms;
    logic [15:0] hold_val;
    logic [15:0] act;
    logic [7:0] flags;
    logic asm7_q;
    logic settle_go;
    plab_rsp_s rsp;
  } plab_state_s;
endpackage

// [core/plab_settle_timer.sv]
`timescale 1ns/1ps
module plab_settle_timer
  import plab_pkg::*;
#(
  parameter int W = 16
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_start,
  input wire logic i_tick,
  input wire logic [W-1:0] i_len,
  output logic o_settled
);
  // -----------------------------------------------------------------
  // elaboration check
  // -----------------------------------------------------------------
  if (W != 16) begin : g_bad_w
    $error("settle timer only serves 16 bit lengths");
  end

  plab_tmr_s st_ff; // registered state
  plab_tmr_s nxt_st; // next state

  // -----------------------------------------------------------------
  // countdown in millisecond ticks
  // -----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    if (i_start) begin
      // restart wins over a tick in the same cycle
      nxt_st.cnt = i_len;
      nxt_st.settled = (i_len == 16'h0000);
    end else if (i_tick && !st_ff.settled) begin
      nxt_st.cnt = st_ff.cnt - 16'h0001;
      nxt_st.settled = (st_ff.cnt == 16'h0001);
    end
  end

  // state register; settled after reset so nothing is masked before a command
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_ff <= '{cnt: 16'h0000, settled: 1'b1};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_settled = st_ff.settled;

  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  chk_timer_mask: assert property (i_start && i_len != 16'h0000 |=> !o_settled)
    else $error("timer not masking after start");
endmodule

// [verification/plab_master.sv]
`timescale 1ns/1ps
// -----------------------------------------------------------------
// fieldbus master model: issues single get/set attribute accesses
// -----------------------------------------------------------------
module plab_master
  import plab_pkg::*;
(
  input wire logic i_clock, // bank clock
  output plab_req_s o_req, // access towards the bank
  input wire plab_rsp_s i_rsp // answer from the bank
);
  // idle bus until the first access
  initial begin
    o_req = '0;
  end
  // one access: request for one cycle, answer sampled one cycle later
  // caller also writes format and units while executing, to check the lock
  task automatic access(input logic wr, input logic [7:0] attr, input logic [31:0] wd,
                        output logic ack, output logic err, output logic [31:0] rd);
    @(negedge i_clock);
    o_req.req <= 1'b1;
    o_req.write <= wr;
    o_req.attr <= attr;
    o_req.wdata <= wd;
    @(negedge i_clock);
    // the answer stands only in the cycle after the taking edge
    ack = i_rsp.ack;
    err = i_rsp.err;
    rd = i_rsp.rdata;
    // released fields turn over so stale values never pass for valid ones
    o_req.req <= 1'b0;
    o_req.write <= ~wr;
    o_req.attr <= ~attr;
    o_req.wdata <= ~wd;
  endtask
endmodule

// [verification/test_pressure_loop_attr_bank.sv]
`timescale 1ns/1ps
`include "plab_consts.svh"
module test_pressure_loop_attr_bank;
  import plab_pkg::*;
  // -----------------------------------------------------------------
  // signals and tables
  // -----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic [7:0] attr;
    logic [31:0] wd;
    logic err;
    logic [31:0] rd;
  } plab_row_s; // one access and its expected answer
  logic i_clock, i_reset_n, i_executing, i_io_active, i_asm7;
  logic [15:0] i_sensor, i_loop_out, i_ao_value, i_safe_value;
  logic [1:0] i_safe_state;
  plab_req_s req; // from the master model
  plab_rsp_s rsp; // from the bank
  logic [15:0] eff, act; // effective setpoint, actuator
  logic [7:0] flags; // status byte
  logic ramping;
  int mismatches, n_checks;
  logic r_ack, r_err; // last answer
  logic [31:0] r_rd;
  localparam int N_ROWS = 28;
  plab_row_s rows [N_ROWS] = '{
    '{1'b0, 8'h01, 32'h0, 1'b0, 32'h0D}, '{1'b1, 8'h01, 32'h5, 1'b1, 32'h0},
    '{1'b0, 8'h03, 32'h0, 1'b0, 32'hC3}, '{1'b0, 8'h04, 32'h0, 1'b0, 32'h1001},
    '{1'b0, 8'h05, 32'h0, 1'b0, 32'h0}, '{1'b0, 8'h0B, 32'h0, 1'b0, 32'h0},
    '{1'b0, 8'h0C, 32'h0, 1'b0, 32'h0}, '{1'b0, 8'h0D, 32'h0, 1'b0, 32'h0},
    '{1'b0, 8'h0F, 32'h0, 1'b0, 32'h0}, '{1'b0, 8'h0E, 32'h0, 1'b0, 32'h0},
    '{1'b0, 8'h10, 32'h0, 1'b0, 32'h0}, '{1'b0, 8'h13, 32'h0, 1'b0, 32'h0},
    '{1'b1, 8'h03, 32'h55, 1'b1, 32'h0}, '{1'b1, 8'h03, 32'hCA, 1'b0, 32'h0},
    '{1'b0, 8'h03, 32'h0, 1'b0, 32'hCA}, '{1'b1, 8'h03, 32'hC3, 1'b0, 32'h0},
    '{1'b1, 8'h04, 32'h1300, 1'b0, 32'h0}, '{1'b0, 8'h04, 32'h0, 1'b0, 32'h1300},
    '{1'b1, 8'h04, 32'h2000, 1'b1, 32'h0}, '{1'b1, 8'h05, 32'h5, 1'b1, 32'h0},
    '{1'b1, 8'h0B, 32'h2, 1'b1, 32'h0}, '{1'b1, 8'h07, 32'h0, 1'b1, 32'h0},
    '{1'b1, 8'h0A, 32'h0, 1'b1, 32'h0}, '{1'b0, 8'h11, 32'h0, 1'b1, 32'h0},
    '{1'b1, 8'h13, 32'hFFFFFFFF, 1'b0, 32'h0}, '{1'b0, 8'h13, 32'h0, 1'b0, 32'hFFFFFFFF},
    '{1'b1, 8'h13, 32'h0, 1'b0, 32'h0}, '{1'b1, 8'h0D, 32'hFFFF, 1'b0, 32'h0}
  };
  logic [15:0] sp_in [6] = '{16'hFFFF, 16'h8000, 16'h6000, 16'h6999, 16'h699A, 16'h7FFF};
  logic [15:0] sp_exp [6] = '{16'h0, 16'h0, 16'h6000, 16'h6999, 16'h6999, 16'h6999};
  logic [15:0] mode_exp [4] = '{16'h1234, 16'h0, 16'h6000, 16'h0ABC};
  logic [15:0] safe_exp [4] = '{16'h0, 16'h6000, 16'h0DEF, 16'h0777};
  // -----------------------------------------------------------------
  // instances
  // -----------------------------------------------------------------
  // short tick so settling and ramp spans cost a few cycles each
  plab_bank #(.CYC_PER_MS(4)) i_dut (.I_CLOCK(i_clock), .I_RESET_N(i_reset_n), .I_REQ(req),
    .I_EXECUTING(i_executing), .I_IO_ACTIVE(i_io_active), .I_ASM7_CONSUME(i_asm7),
    .I_SENSOR(i_sensor), .I_LOOP_OUT(i_loop_out), .I_AO_VALUE(i_ao_value),
    .I_SAFE_STATE(i_safe_state), .I_SAFE_VALUE(i_safe_value), .O_RSP(rsp),
    .O_EFF_SETPOINT(eff), .O_ACTUATOR(act), .O_FLAGS(flags), .O_RAMPING(ramping));
  plab_master i_master (.i_clock(i_clock), .o_req(req), .i_rsp(rsp));
  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  // 4 ns clock
  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // access through the master, answer always checked for ack and err
  task automatic rw(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic ex_err);
    i_master.access(wr, a, wd, r_ack, r_err, r_rd);
    chk("ack", 32'h1, 32'(r_ack));
    chk("err", 32'(ex_err), 32'(r_err));
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge i_clock);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge i_clock);
    mismatches++;
    $display("watchdog expired");
    give_verdict();
  end
  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    i_reset_n = 1'b0;
    {i_executing, i_io_active, i_asm7, i_safe_state} = '0;
    {i_sensor, i_ao_value, i_safe_value} = '0;
    i_loop_out = 16'h1234;
    repeat (16) @(posedge i_clock);
    @(negedge i_clock);
    chk("flags in reset", 32'h0, 32'(flags));
    chk("eff in reset", 32'h0, 32'(eff));
    i_reset_n = 1'b1;
    // table of plain accesses
    for (int i = 0; i < N_ROWS; i++) begin
      rw(rows[i].wr, rows[i].attr, rows[i].wd, rows[i].err);
      if (!rows[i].wr) chk("rdata", rows[i].rd, r_rd);
    end
    rw(1'b1, `PLAB_ID_ALM_SETTLE, 32'h0, 1'b0);
    // setpoint range and clamps, ramp disabled
    for (int i = 0; i < 6; i++) begin
      rw(1'b1, `PLAB_ID_TARGET, 32'(sp_in[i]), 1'b0);
      chk("eff setpoint", 32'(sp_exp[i]), 32'(eff));
    end
    // measured value mirrors sensor
    i_sensor = 16'h0321;
    rw(1'b0, `PLAB_ID_MEASURED, 32'h0, 1'b0);
    chk("measured", 32'h0321, r_rd);
    // override modes 0..3; hold must ignore later analog output changes
    i_safe_value = 16'h0777;
    for (int m = 0; m < 4; m++) begin
      i_ao_value = 16'h0ABC;
      rw(1'b1, `PLAB_ID_MODE, 32'(m), 1'b0);
      i_ao_value = 16'h0DEF;
      wait_n(2);
      chk("actuator", 32'(mode_exp[m]), 32'(act));
    end
    // safe state mode follows the actuator safe state selection
    rw(1'b1, `PLAB_ID_MODE, 32'h4, 1'b0);
    for (int s = 0; s < 4; s++) begin
      i_safe_state = 2'(s);
      wait_n(3);
      chk("safe actuator", 32'(safe_exp[s]), 32'(act));
    end
    rw(1'b1, `PLAB_ID_MODE, 32'h0, 1'b0);
    // alarm flag: enable, strict band, absolute deviation
    rw(1'b1, `PLAB_ID_ALM_EN, 32'h1, 1'b0);
    rw(1'b1, `PLAB_ID_ALM_BAND, 32'h10, 1'b0);
    i_sensor = 16'h1011;
    rw(1'b1, `PLAB_ID_TARGET, 32'h1000, 1'b0);
    wait_n(3);
    chk("alarm set", 32'h01, 32'(flags));
    i_sensor = 16'h1010;
    wait_n(3);
    chk("alarm at band", 32'h00, 32'(flags));
    i_sensor = 16'h0FEF;
    wait_n(3);
    chk("alarm below", 32'h01, 32'(flags));
    rw(1'b1, `PLAB_ID_ALM_EN, 32'h0, 1'b0);
    wait_n(3);
    chk("alarm disabled", 32'h00, 32'(flags));
    // warning flag and settling mask on alarm only
    rw(1'b1, `PLAB_ID_WRN_EN, 32'h1, 1'b0);
    rw(1'b1, `PLAB_ID_WRN_BAND, 32'h20, 1'b0);
    i_sensor = 16'h1021;
    wait_n(3);
    chk("warning set", 32'h02, 32'(flags));
    rw(1'b1, `PLAB_ID_ALM_EN, 32'h1, 1'b0);
    rw(1'b1, `PLAB_ID_ALM_SETTLE, 32'h3, 1'b0);
    rw(1'b1, `PLAB_ID_TARGET, 32'h1000, 1'b0);
    wait_n(2);
    chk("alarm masked", 32'h02, 32'(flags));
    wait_n(20);
    chk("alarm settled", 32'h03, 32'(flags));
    // ramp from 0x1000 to 0x2000 over 4 ms
    rw(1'b1, `PLAB_ID_RAMP, 32'h4, 1'b0);
    rw(1'b1, `PLAB_ID_TARGET, 32'h2000, 1'b0);
    chk("ramping", 32'h1, 32'(ramping));
    wait_n(9);
    chk("ramp mid", 32'h1, 32'(eff > 16'h1000 && eff < 16'h2000));
    wait_n(24);
    chk("ramp end", 32'h2000, 32'(eff));
    chk("ramp done", 32'h0, 32'(ramping));
    rw(1'b1, `PLAB_ID_RAMP, 32'h0, 1'b0);
    // format and units locks
    i_executing = 1'b1;
    rw(1'b1, `PLAB_ID_FORMAT, 32'hCA, 1'b1);
    rw(1'b1, `PLAB_ID_UNITS, 32'h1300, 1'b1);
    i_executing = 1'b0;
    i_io_active = 1'b1;
    rw(1'b1, `PLAB_ID_FORMAT, 32'hCA, 1'b1);
    rw(1'b1, `PLAB_ID_UNITS, 32'h1001, 1'b0);
    i_io_active = 1'b0;
    rw(1'b1, `PLAB_ID_FORMAT, 32'hCA, 1'b0);
    // instance 7 activation forces INT, kept after it ends
    i_asm7 = 1'b1;
    wait_n(3);
    i_asm7 = 1'b0;
    rw(1'b0, `PLAB_ID_FORMAT, 32'h0, 1'b0);
    chk("forced format", 32'hC3, r_rd);
    // reset in mid-run: mode comes back to normal
    rw(1'b1, `PLAB_ID_MODE, 32'h1, 1'b0);
    i_reset_n = 1'b0;
    wait_n(1);
    chk("flags mid reset", 32'h0, 32'(flags));
    i_reset_n = 1'b1;
    rw(1'b0, `PLAB_ID_MODE, 32'h0, 1'b0);
    chk("mode after reset", 32'h0, r_rd);
    give_verdict();
  end
endmodule
